// ### rtc_ctrl.v
// Real-time clock control and oscillator registers over AHB-Lite
`timescale 1ns/100ps
`include "rtc_ctrl_map.vh"
module rtc_ctrl #(
  parameter TIMER_WIDTH = 32
) (
  input  wire        clock,
  input  wire        resetn,
  input  wire        clock_en,
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  input  wire        osc_tick,
  input  wire        missing_clock_event,
  input  wire        amplitude_ok,
  output reg         osc_enable_bit,
  output reg         missing_clock_detect_enable,
  output reg         gain_control_enable,
  output reg         osc_mode_select,
  output reg         bias_double_enable,
  output reg         alarm_event
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  reg                    osc_fail_flag_q;
  reg                    timer_run_bit_q;
  reg                    alarm_enable_bit_q;
  reg                    autoreset_q;
  reg                    alarm_flag_q;
  reg                    load_pend_q;
  reg                    snap_pend_q;
  reg                    amp_valid_q;
  reg [TIMER_WIDTH-1:0]  snapshot_regs_q;
  reg [TIMER_WIDTH-1:0]  alarm_match_regs_q;
  reg                    wr_pend_q;
  reg [11:0]             addr_q;
  wire [TIMER_WIDTH-1:0] timer_count;
  wire                   match;
  wire                   load_go;
  wire                   snap_go;
  wire                   wr_cc;
  wire                   wr_oc;
  wire                   addr_phase;
  reg  [31:0]            rdata_d;

  // ---------------------------------------------------------------
  // Timer
  // ---------------------------------------------------------------
  assign load_go = load_pend_q;
  assign snap_go = snap_pend_q && !load_pend_q;

  rtc_timer #(
    .WIDTH (TIMER_WIDTH)
  ) u_timer (
    .clock      (clock),
    .resetn     (resetn),
    .enable     (clock_en),
    .tick       (osc_tick && osc_enable_bit),
    .run        (timer_run_bit_q),
    .load       (load_go),
    .load_value (snapshot_regs_q),
    .clear      (alarm_flag_q && autoreset_q),
    .count_q    (timer_count)
  );

  assign match = alarm_enable_bit_q && (timer_count == alarm_match_regs_q);

  // ---------------------------------------------------------------
  // Bus slave: address phase capture, zero-wait data phase
  // ---------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_cc = wr_pend_q && (addr_q == `ADDR_CLOCK_CONTROL);
  assign wr_oc = wr_pend_q && (addr_q == `ADDR_OSCILLATOR_CONTROL);

  always @(posedge clock) begin
    if (!resetn) begin
      wr_pend_q <= 1'b0;
      addr_q    <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (clock_en) begin
      wr_pend_q <= addr_phase && hwrite;
      if (addr_phase) begin
        addr_q <= haddr;
      end
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    case (haddr)
      `ADDR_CLOCK_CONTROL: begin
        rdata_d[7:0] = {osc_enable_bit, missing_clock_detect_enable,
                        osc_fail_flag_q, timer_run_bit_q, alarm_enable_bit_q,
                        alarm_flag_q, load_pend_q, snap_pend_q};
      end
      `ADDR_OSCILLATOR_CONTROL: begin
        rdata_d[7:0] = {gain_control_enable, osc_mode_select,
                        bias_double_enable, amp_valid_q, 4'h0};
      end
      `ADDR_CAPTURE: begin
        rdata_d = snapshot_regs_q;
      end
      `ADDR_ALARM: begin
        rdata_d = alarm_match_regs_q;
      end
      `ADDR_TIMER_STATUS: begin
        rdata_d = timer_count;
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock) begin
    if (!resetn) begin
      hrdata <= 32'h0000_0000;
    end else if (clock_en && addr_phase && !hwrite) begin
      hrdata <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      osc_enable_bit              <= 1'b0;
      missing_clock_detect_enable <= 1'b0;
      osc_fail_flag_q             <= 1'b0;
      timer_run_bit_q             <= 1'b0;
      alarm_enable_bit_q          <= 1'b0;
      autoreset_q                 <= 1'b0;
      alarm_flag_q                <= 1'b0;
      load_pend_q                 <= 1'b0;
      snap_pend_q                 <= 1'b0;
      alarm_event                 <= 1'b0;
    end else if (clock_en) begin
      if (wr_cc) begin
        osc_enable_bit              <= hwdata[`CC_OSC_EN];
        missing_clock_detect_enable <= hwdata[`CC_MCD_EN];
        timer_run_bit_q             <= hwdata[`CC_RUN];
        alarm_enable_bit_q          <= hwdata[`CC_ALARM_EN];
        autoreset_q                 <= hwdata[`CC_ALARM_FLAG];
      end
      // Fail flag: detector set wins over software clear
      if (missing_clock_detect_enable && missing_clock_event) begin
        osc_fail_flag_q <= 1'b1;
      end else if (wr_cc && !hwdata[`CC_OSC_FAIL]) begin
        osc_fail_flag_q <= 1'b0;
      end
      // Alarm flag pulses for one oscillator tick only
      if (wr_cc && !hwdata[`CC_ALARM_EN]) begin
        alarm_flag_q <= 1'b0;
      end else if (osc_tick && osc_enable_bit) begin
        alarm_flag_q <= match && !alarm_flag_q;
      end
      alarm_event <= alarm_flag_q;
      // Triggers: only a one starts, done clears
      if (wr_cc && hwdata[`CC_LOAD]) begin
        load_pend_q <= 1'b1;
      end else if (load_go) begin
        load_pend_q <= 1'b0;
      end
      if (wr_cc && hwdata[`CC_SNAP]) begin
        snap_pend_q <= 1'b1;
      end else if (snap_go) begin
        snap_pend_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Oscillator register
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      gain_control_enable <= 1'b0;
      osc_mode_select     <= 1'b0;
      bias_double_enable  <= 1'b0;
      amp_valid_q         <= 1'b0;
    end else if (clock_en) begin
      amp_valid_q <= amplitude_ok && osc_enable_bit;
      if (wr_oc) begin
        gain_control_enable <= hwdata[`OC_GAIN_EN];
        osc_mode_select     <= hwdata[`OC_MODE];
        bias_double_enable  <= hwdata[`OC_BIAS_X2];
      end
    end
  end

  // ---------------------------------------------------------------
  // Capture and alarm words
  // ---------------------------------------------------------------
  always @(posedge clock) begin
    if (!resetn) begin
      snapshot_regs_q    <= `RST_WORD;
      alarm_match_regs_q <= `RST_WORD;
    end else if (clock_en) begin
      if (snap_go) begin
        snapshot_regs_q <= timer_count;
      end else if (wr_pend_q && addr_q == `ADDR_CAPTURE) begin
        snapshot_regs_q <= hwdata[TIMER_WIDTH-1:0];
      end
      if (wr_pend_q && addr_q == `ADDR_ALARM) begin
        alarm_match_regs_q <= hwdata[TIMER_WIDTH-1:0];
      end
    end
  end

endmodule

// ### rtc_ctrl_map.vh
// Register map and field constants of the clock control block
`ifndef RTC_CTRL_MAP_VH
`define RTC_CTRL_MAP_VH

// Register indices; byte address is four times the index
`define IDX_CLOCK_CONTROL      8'h04
`define IDX_OSCILLATOR_CONTROL 8'h05
`define IDX_CAPTURE            8'h00
`define IDX_ALARM              8'h08
`define IDX_TIMER_STATUS       8'h10
`define ADDR_CLOCK_CONTROL      12'h010
`define ADDR_OSCILLATOR_CONTROL 12'h014
`define ADDR_CAPTURE            12'h000
`define ADDR_ALARM              12'h020
`define ADDR_TIMER_STATUS       12'h040

// Clock control fields
`define CC_OSC_EN     7
`define CC_MCD_EN     6
`define CC_OSC_FAIL   5
`define CC_RUN        4
`define CC_ALARM_EN   3
`define CC_ALARM_FLAG 2
`define CC_LOAD       1
`define CC_SNAP       0

// Oscillator control fields
`define OC_GAIN_EN    7
`define OC_MODE       6
`define OC_BIAS_X2    5
`define OC_AMP_VALID  4

`define RST_CLOCK_CONTROL 8'h00
`define RST_OSC_CONTROL   8'h00
`define RST_WORD          32'h0000_0000

`endif

// ### rtc_ctrl_sva.sv
// Port assertions for the clock control block
`timescale 1ns/100ps
`include "rtc_ctrl_map.vh"
module rtc_ctrl_sva (
  input wire        clock,
  input wire        resetn,
  input wire        clock_en,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        osc_tick,
  input wire        osc_enable_bit,
  input wire        missing_clock_detect_enable,
  input wire        gain_control_enable,
  input wire        osc_mode_select,
  input wire        bias_double_enable,
  input wire        alarm_event
);
  wire go = hsel & hready & htrans[1] & clock_en;
  wire cc = haddr == `ADDR_CLOCK_CONTROL;
  wire oc = haddr == `ADDR_OSCILLATOR_CONTROL;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  bus_ready_a: assert property (hreadyout)
    else $error("slave not ready");
  bus_okay_a: assert property (!hresp)
    else $error("slave response not okay");
  reset_off_a: assert property (
    !$past(resetn) && $past(clock_en) |-> !osc_enable_bit && !gain_control_enable)
    else $error("control bits not cleared by reset");
  ctrl_write_a: assert property (
    go && hwrite && cc ##1 clock_en |=> osc_enable_bit == $past(hwdata[7])
    && missing_clock_detect_enable == $past(hwdata[6]))
    else $error("control write not applied");
  osc_write_a: assert property (
    go && hwrite && oc ##1 clock_en |=> {gain_control_enable, osc_mode_select,
    bias_double_enable} == $past(hwdata[7:5]))
    else $error("oscillator write not applied");
  ctrl_read_a: assert property (
    go && !hwrite && cc |=> hrdata[7:6] == {osc_enable_bit, missing_clock_detect_enable}
    && hrdata[31:8] == 24'h00_0000)
    else $error("control read wrong");
  osc_read_a: assert property (
    go && !hwrite && oc |=> hrdata[7:5] == {gain_control_enable, osc_mode_select,
    bias_double_enable} && {hrdata[31:8], hrdata[3:0]} == 28'h000_0000)
    else $error("oscillator read wrong");
  alarm_pulse_a: assert property (
    osc_tick && alarm_event && clock_en |-> ##2 !alarm_event)
    else $error("alarm flag outlived one tick");
endmodule

bind rtc_ctrl rtc_ctrl_sva rtc_ctrl_sva_inst (.clock, .resetn, .clock_en, .hsel, .haddr,
  .htrans, .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .osc_tick,
  .osc_enable_bit, .missing_clock_detect_enable, .gain_control_enable, .osc_mode_select,
  .bias_double_enable, .alarm_event);

// ### rtc_ctrl_tb.sv
// Self-checking bench for the clock control block
`timescale 1ns/100ps
`include "rtc_ctrl_map.vh"
module rtc_ctrl_tb;
  localparam [11:0] CTL = `ADDR_CLOCK_CONTROL;
  localparam [11:0] OSC = `ADDR_OSCILLATOR_CONTROL;
  localparam [11:0] CAP = `ADDR_CAPTURE;
  localparam [11:0] TMR = `ADDR_TIMER_STATUS;
  logic        clock = 0, resetn = 0, hsel = 0, hwrite = 0, osc_tick = 0;
  logic        missing_clock_event = 0, amplitude_ok = 0, clock_en = 1;
  logic [11:0] haddr = 0;
  logic [1:0]  htrans = 0;
  logic [31:0] hwdata = 0, r, s;
  wire  [31:0] hrdata;
  wire         hreadyout, alarm_event;
  int          fails = 0, checks_done = 0, cyc = 0, i;
  rtc_ctrl rtc_ctrl_inst (.clock(clock), .resetn(resetn), .clock_en(clock_en), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .osc_tick(osc_tick),
    .missing_clock_event(missing_clock_event), .amplitude_ok(amplitude_ok),
    .osc_enable_bit(), .missing_clock_detect_enable(), .gain_control_enable(),
    .osc_mode_select(), .bias_double_enable(), .alarm_event(alarm_event));
  // ----------------------------------------
  // Clock, oscillator ticks and hang guard
  // ----------------------------------------
  always #10 clock = ~clock;
  always @(posedge clock) begin
    cyc <= cyc + 1;
    osc_tick <= (cyc % 4 == 3);
    if (cyc == 20000) begin
      fails = fails + 1;
      summarize();
    end
  end
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  // One single-word bus transfer; read data lands in r
  task xf(input w, input [11:0] a, input [31:0] d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 0;
    htrans <= 0;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    r = hrdata;
  endtask
  task poll(input int b);
    for (i = 0; i < 20; i++) begin
      xf(0, CTL, 0);
      if (r[b] === 1'b0) break;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_reset;
    xf(0, CTL, 0);
    chk(r, 32'h0000_0000);
    xf(0, OSC, 0);
    chk(r, 32'h0000_0000);
    xf(0, 12'h0fc, 0);
    chk(r, 32'h0000_0000);
  endtask
  task t_osc;
    amplitude_ok <= 1;
    xf(1, OSC, 32'hffff_ffff);
    xf(0, OSC, 0);
    chk(r, 32'h0000_00e0);
    xf(1, CTL, 32'h0000_0080);
    @(posedge clock);
    xf(0, OSC, 0);
    chk(r, 32'h0000_00f0);
    amplitude_ok <= 0;
    xf(1, OSC, 32'h0000_0040);
    xf(0, OSC, 0);
    chk(r, 32'h0000_0040);
  endtask
  task t_load;
    xf(1, CAP, 32'h1234_5678);
    xf(1, CTL, 32'h0000_0082);
    poll(1);
    chk(r[1], 1'b0);
    xf(0, TMR, 0);
    chk(r, 32'h1234_5678);
    xf(1, CAP, 0);
    xf(1, CTL, 32'h0000_0081);
    poll(0);
    chk(r[0], 1'b0);
    xf(0, CAP, 0);
    chk(r, 32'h1234_5678);
  endtask
  task t_run;
    xf(1, CTL, 32'h0000_0090);
    repeat (40) @(posedge clock);
    xf(1, CTL, 32'h0000_0080);
    xf(0, TMR, 0);
    s = r;
    repeat (20) @(posedge clock);
    xf(0, TMR, 0);
    chk(r, s);
    chk(s > 32'h1234_5678, 1);
  endtask
  task t_alarm;
    xf(1, CAP, 0);
    xf(1, CTL, 32'h0000_0082);
    poll(1);
    xf(1, `ADDR_ALARM, 32'h0000_0005);
    xf(1, CTL, 32'h0000_009c);
    xf(0, CTL, 0);
    chk(r, 32'h0000_0098);
    for (i = 0; i < 100 && alarm_event !== 1'b1; i++) @(posedge clock);
    chk(alarm_event, 1);
    xf(0, CTL, 0);
    chk(r[2], 1'b1);
    repeat (8) @(posedge clock);
    xf(0, TMR, 0);
    chk(r < 5, 1);
    xf(1, CTL, 32'h0000_0080);
  endtask
  task t_fail;
    xf(1, CTL, 32'h0000_00d0);
    missing_clock_event <= 1;
    @(posedge clock);
    missing_clock_event <= 0;
    @(posedge clock);
    xf(0, CTL, 0);
    chk(r, 32'h0000_00f0);
    xf(1, CTL, 32'h0000_00d0);
    xf(0, CTL, 0);
    chk(r, 32'h0000_00d0);
  endtask
  task t_freeze;
    xf(1, CTL, 32'h0000_0090);
    xf(0, TMR, 0);
    s = r;
    clock_en <= 0;
    repeat (40) @(posedge clock);
    clock_en <= 1;
    xf(0, TMR, 0);
    chk(r - s < 2, 1);
    xf(1, CTL, 32'h0000_0080);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1;
    t_reset();
    t_osc();
    t_load();
    t_run();
    t_alarm();
    t_fail();
    t_freeze();
    summarize();
  end
endmodule

// ### rtc_timer.v
// 32-bit timer counting ticks while run is set, with load and auto-clear
`timescale 1ns/100ps
module rtc_timer #(
  parameter WIDTH = 32
) (
  input  wire             clock,
  input  wire             resetn,
  input  wire             enable,
  input  wire             tick,
  input  wire             run,
  input  wire             load,
  input  wire [WIDTH-1:0] load_value,
  input  wire             clear,
  output reg  [WIDTH-1:0] count_q
);

  always @(posedge clock) begin
    if (!resetn) begin
      count_q <= {WIDTH{1'b0}};
    end else if (enable) begin
      if (load) begin
        count_q <= load_value;
      end else if (clear && tick) begin
        count_q <= {WIDTH{1'b0}};
      end else if (run && tick) begin
        count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule
